// [logic/gp_timer_map.svh]
`ifndef GP_TIMER_MAP_SVH
`define GP_TIMER_MAP_SVH

// Register byte offsets
`define GT_TIMER_CONFIG_OFS 8'h8C
`define GT_TIMER_COUNT_OFS 8'h90
`define GT_WORD_ORDER_OFS 8'h98
`define GT_FREE_COUNT_OFS 8'h9C

// Field positions
`define GT_RUN_EN_BIT 29
`define GT_PRELOAD_MSB 15
`define GT_PRELOAD_LSB 0

// Reset values and word swap key
`define GT_PRELOAD_RST 16'hFFFF
`define GT_COUNT_RST 16'hFFFF
`define GT_WORD_ORDER_RST 32'h0000_0000
`define GT_WORD_SWAP_KEY 32'hFFFF_FFFF
`define GT_FREE_RST 32'h0000_0000

// Timing
`define GT_SYS_MHZ 250
`define GT_TICK_MHZ 25
`define GT_TICK_DIV (`GT_SYS_MHZ / `GT_TICK_MHZ)
`define GT_FREE_CLR_NS 160
`define GT_FREE_CLR_CYC ((`GT_FREE_CLR_NS * `GT_SYS_MHZ) / 1000)

`endif

// [logic/gp_timer_pkg.sv]
package gp_timer_pkg;

    // Captured AHB address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ahb_req_t;

    // Timer control fields
    typedef struct packed {
        logic        run_en;
        logic [15:0] timer_preload;
    } timer_cfg_t;

    // Network-side word serialiser
    typedef enum logic [0:0] {
        TX_LOW  = 1'b0,
        TX_HIGH = 1'b1
    } tx_state_t;

    // Half-word snapshot of the free counter
    typedef enum logic [0:0] {
        SNAP_IDLE = 1'b0,
        SNAP_HELD = 1'b1
    } snap_state_t;

endpackage

// [logic/gp_timer_freerun_wordswap.sv]
// Functional notes
// RULE_01: Timer run-enable bit 29 set starts the timer, cleared halts it.
// RULE_02: Falling edge of run-enable forces the preload field to FFFFh.
// RULE_03: Preload field bits 15-0 is read-write, resets to FFFFh.
// RULE_04: Live timer value reads in low half of count view, FFFFh at reset.
// RULE_05: Timer raises an event at intervals set by the preload value.
// RULE_06: Word order all ones: A[1] set selects low half, clear selects high.
// RULE_07: Any other word order: A[1] set selects high half, clear selects low.
// RULE_08: Network side always sends and receives the low word first.
// RULE_09: 32-bit free counter clears at reset, counts every 25 MHz cycle.
// RULE_10: Free counter wraps from maximum back to zero.
// RULE_11: First half-word read captures the whole free count consistently.
// RULE_12: Free counter is cleared within 160 ns of reset.
// RULE_13: Free counter keeps running in every power state.
// RULE_14: Running timer counts down per tick, flags and reloads past zero.
// RULE_15: Host reads low half of the free count first, high half second.
`timescale 1ns/1ps
`include "gp_timer_map.svh"
module gp_timer_freerun_wordswap #(
    parameter int TICK_DIV = `GT_TICK_DIV
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // 16-bit host view of the free counter
    input wire logic half_rd_i,
    input wire logic half_a1_i,
    output logic [15:0] half_data_o,
    output logic half_is_high_o,
    // Network side word ordering
    input wire logic tx_load_i,
    input wire logic [31:0] tx_word_i,
    output logic tx_ready_o,
    output logic tx_half_valid_o,
    output logic [15:0] tx_half_o,
    input wire logic rx_half_valid_i,
    input wire logic [15:0] rx_half_i,
    output logic rx_word_valid_o,
    output logic [31:0] rx_word_o,
    // Timer event
    output logic timer_event_o
);

    // Elaboration check on the tick divider
    if (TICK_DIV < 2 || TICK_DIV > 255) begin : g_bad_div
        $error("TICK_DIV out of range");
    end

    localparam int CLR_CYC = `GT_FREE_CLR_CYC;
    if (CLR_CYC < 1) begin : g_bad_clr
        $error("Free counter clear window shorter than one cycle");
    end

    // Half select from host A[1] and the word order register
    function automatic logic sel_high(input logic a1, input logic [31:0] order);
        if (order == `GT_WORD_SWAP_KEY) begin
            sel_high = ~a1; // RULE_06
        end else begin
            sel_high = a1; // RULE_07
        end
    endfunction

    gp_timer_pkg::ahb_req_t req_ff;
    gp_timer_pkg::ahb_req_t nxt_req;
    gp_timer_pkg::timer_cfg_t cfg_ff;
    gp_timer_pkg::tx_state_t tx_state_ff;
    gp_timer_pkg::snap_state_t snap_state_ff;
    logic rd_wait_ff;
    logic [31:0] rdata_ff;
    logic [31:0] word_order_ff;
    logic [31:0] free_ff;
    logic [31:0] snap_ff;
    logic [7:0] div_ff;
    logic tick_ff;
    logic [15:0] count_ff;
    logic run_seen_ff;
    logic event_ff;
    logic [15:0] half_data_ff;
    logic half_high_ff;
    logic [15:0] tx_high_ff;
    logic [15:0] tx_half_ff;
    logic tx_valid_ff;
    logic [15:0] rx_low_ff;
    logic rx_have_low_ff;
    logic [31:0] rx_word_ff;
    logic rx_valid_ff;
    logic wr_cfg;
    logic wr_order;
    logic rd_phase;
    logic [15:0] nxt_preload;
    logic nxt_run_en;

    // Address phase capture
    always_comb begin
        nxt_req.valid = hsel_i & hready_i & htrans_i[1];
        nxt_req.write = hwrite_i;
        nxt_req.addr = haddr_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            req_ff <= '0;
        end else if (hready_i) begin
            req_ff <= nxt_req;
        end
    end

    // Reads take one wait state so earlier writes have landed
    assign rd_phase = req_ff.valid & ~req_ff.write & ~rd_wait_ff;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rd_wait_ff <= 1'b0;
        end else begin
            rd_wait_ff <= rd_phase;
        end
    end

    assign hreadyout_o = ~rd_phase;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata_ff;

    // Register write strobes
    assign wr_cfg = req_ff.valid & req_ff.write & (req_ff.addr == `GT_TIMER_CONFIG_OFS);
    assign wr_order = req_ff.valid & req_ff.write & (req_ff.addr == `GT_WORD_ORDER_OFS);

    // Read data mux, unmapped and reserved bits read zero
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_phase) begin
            case (req_ff.addr)
                `GT_TIMER_CONFIG_OFS: begin
                    rdata_ff <= {2'b00, cfg_ff.run_en, 13'h0000, cfg_ff.timer_preload};
                end
                `GT_TIMER_COUNT_OFS: begin
                    rdata_ff <= {16'h0000, count_ff}; // RULE_04
                end
                `GT_WORD_ORDER_OFS: begin
                    rdata_ff <= word_order_ff;
                end
                `GT_FREE_COUNT_OFS: begin
                    rdata_ff <= free_ff;
                end
                default: begin
                    rdata_ff <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Timer configuration next values
    always_comb begin
        nxt_run_en = cfg_ff.run_en;
        nxt_preload = cfg_ff.timer_preload;
        if (wr_cfg) begin
            nxt_run_en = hwdata_i[`GT_RUN_EN_BIT]; // RULE_01
            nxt_preload = hwdata_i[`GT_PRELOAD_MSB:`GT_PRELOAD_LSB]; // RULE_03
        end
        if (cfg_ff.run_en && !nxt_run_en) begin
            nxt_preload = `GT_PRELOAD_RST; // RULE_02
        end
    end

    // Timer configuration register
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            cfg_ff.run_en <= 1'b0;
            cfg_ff.timer_preload <= `GT_PRELOAD_RST; // RULE_03
        end else begin
            cfg_ff.run_en <= nxt_run_en;
            cfg_ff.timer_preload <= nxt_preload;
        end
    end

    // Word order register
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            word_order_ff <= `GT_WORD_ORDER_RST;
        end else if (wr_order) begin
            word_order_ff <= hwdata_i;
        end
    end

    // 25 MHz tick from the system clock
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            div_ff <= 8'h00;
            tick_ff <= 1'b0;
        end else if (div_ff == 8'(TICK_DIV - 1)) begin
            div_ff <= 8'h00;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 8'h01;
            tick_ff <= 1'b0;
        end
    end

    // Free counter, cleared on the first edge of reset, no power gating
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            free_ff <= `GT_FREE_RST; // RULE_09 RULE_12
        end else if (tick_ff) begin
            free_ff <= free_ff + 32'h0000_0001; // RULE_09 RULE_10 RULE_13
        end
    end

    // Timer countdown with reload and event
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            count_ff <= `GT_COUNT_RST; // RULE_04
            run_seen_ff <= 1'b0;
            event_ff <= 1'b0;
        end else begin
            run_seen_ff <= cfg_ff.run_en;
            event_ff <= 1'b0;
            if (cfg_ff.run_en && !run_seen_ff) begin
                count_ff <= cfg_ff.timer_preload; // RULE_01
            end else if (cfg_ff.run_en && tick_ff) begin
                if (count_ff == 16'h0000) begin
                    count_ff <= cfg_ff.timer_preload; // RULE_14
                    event_ff <= 1'b1; // RULE_05
                end else begin
                    count_ff <= count_ff - 16'h0001; // RULE_14
                end
            end
        end
    end

    assign timer_event_o = event_ff;

    // Half-word reads of the free counter with snapshot
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            snap_state_ff <= gp_timer_pkg::SNAP_IDLE;
            snap_ff <= 32'h0000_0000;
            half_data_ff <= 16'h0000;
            half_high_ff <= 1'b0;
        end else if (half_rd_i) begin
            half_high_ff <= sel_high(half_a1_i, word_order_ff);
            case (snap_state_ff)
                gp_timer_pkg::SNAP_IDLE: begin
                    snap_ff <= free_ff; // RULE_11
                    snap_state_ff <= gp_timer_pkg::SNAP_HELD;
                    if (sel_high(half_a1_i, word_order_ff)) begin
                        half_data_ff <= free_ff[31:16];
                    end else begin
                        half_data_ff <= free_ff[15:0]; // RULE_15
                    end
                end
                gp_timer_pkg::SNAP_HELD: begin
                    snap_state_ff <= gp_timer_pkg::SNAP_IDLE;
                    if (sel_high(half_a1_i, word_order_ff)) begin
                        half_data_ff <= snap_ff[31:16]; // RULE_11 RULE_15
                    end else begin
                        half_data_ff <= snap_ff[15:0];
                    end
                end
                default: begin
                    snap_state_ff <= gp_timer_pkg::SNAP_IDLE;
                end
            endcase
        end
    end

    assign half_data_o = half_data_ff;
    assign half_is_high_o = half_high_ff;

    // Transmit serialiser, low word leaves first
    assign tx_ready_o = (tx_state_ff == gp_timer_pkg::TX_LOW);

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            tx_state_ff <= gp_timer_pkg::TX_LOW;
            tx_high_ff <= 16'h0000;
            tx_half_ff <= 16'h0000;
            tx_valid_ff <= 1'b0;
        end else begin
            case (tx_state_ff)
                gp_timer_pkg::TX_LOW: begin
                    tx_valid_ff <= tx_load_i;
                    if (tx_load_i) begin
                        tx_half_ff <= tx_word_i[15:0]; // RULE_08
                        tx_high_ff <= tx_word_i[31:16];
                        tx_state_ff <= gp_timer_pkg::TX_HIGH;
                    end
                end
                gp_timer_pkg::TX_HIGH: begin
                    tx_half_ff <= tx_high_ff; // RULE_08
                    tx_valid_ff <= 1'b1;
                    tx_state_ff <= gp_timer_pkg::TX_LOW;
                end
                default: begin
                    tx_state_ff <= gp_timer_pkg::TX_LOW;
                    tx_valid_ff <= 1'b0;
                end
            endcase
        end
    end

    assign tx_half_valid_o = tx_valid_ff;
    assign tx_half_o = tx_half_ff;

    // Receive assembler, first half lands in the low word
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rx_low_ff <= 16'h0000;
            rx_have_low_ff <= 1'b0;
            rx_word_ff <= 32'h0000_0000;
            rx_valid_ff <= 1'b0;
        end else begin
            rx_valid_ff <= 1'b0;
            if (rx_half_valid_i) begin
                if (!rx_have_low_ff) begin
                    rx_low_ff <= rx_half_i; // RULE_08
                    rx_have_low_ff <= 1'b1;
                end else begin
                    rx_word_ff <= {rx_half_i, rx_low_ff}; // RULE_08
                    rx_have_low_ff <= 1'b0;
                    rx_valid_ff <= 1'b1;
                end
            end
        end
    end

    assign rx_word_valid_o = rx_valid_ff;
    assign rx_word_o = rx_word_ff;

endmodule

// [testbench/gp_timer_props.sv]
`timescale 1ns/1ps
module gp_timer_props (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic tx_load_i,
    input wire logic [31:0] tx_word_i,
    input wire logic tx_ready_o,
    input wire logic tx_half_valid_o,
    input wire logic [15:0] tx_half_o,
    input wire logic rx_half_valid_i,
    input wire logic rx_word_valid_o,
    input wire logic timer_event_o
);
    logic [31:0] word_ff;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    // Word held while the serialiser sends it
    always_ff @(posedge sys_clk_i) begin
        if (tx_load_i && tx_ready_o) begin
            word_ff <= tx_word_i;
        end
    end
    sequence s_take;
        hsel_i && hready_i && htrans_i[1];
    endsequence
    sequence s_tx_take;
        tx_load_i && tx_ready_o;
    endsequence
    sequence s_tx_halves;
        tx_half_valid_o && tx_half_o == word_ff[15:0] ##1
            tx_half_valid_o && tx_half_o == word_ff[31:16];
    endsequence
    a_resp_okay: assert property (!hresp_o) else $error("response not okay");
    a_read_wait: assert property (s_take and !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait state wrong");
    a_write_nowait: assert property (s_take and hwrite_i |=> hreadyout_o)
        else $error("write stalled");
    a_tx_low_first: assert property (s_tx_take |=> s_tx_halves)
        else $error("transmit half order wrong");
    a_tx_busy: assert property (s_tx_take |=> !tx_ready_o ##1 tx_ready_o)
        else $error("transmit busy time wrong");
    a_event_pulse: assert property (timer_event_o |=> !timer_event_o)
        else $error("timer event too long");
    a_rx_after_half: assert property (rx_word_valid_o |-> $past(rx_half_valid_i))
        else $error("word without half");
    a_reset_quiet: assert property ($rose(rstn_i) |-> hreadyout_o && !timer_event_o
        && !tx_half_valid_o && !rx_word_valid_o) else $error("outputs busy after reset");
endmodule

// [testbench/gp_host16_model.sv]
`timescale 1ns/1ps
module gp_host16_model (
    input wire logic sys_clk_i,
    output logic half_rd_o,
    output logic half_a1_o,
    input wire logic [15:0] half_data_i,
    input wire logic half_is_high_i
);
    initial begin
        half_rd_o = 1'b0;
        half_a1_o = 1'b0;
    end
    // One half-word read; address bit is not held past the strobe
    task automatic rd16(input logic a1, output logic [15:0] d, output logic hi);
        @(posedge sys_clk_i);
        half_rd_o <= 1'b1;
        half_a1_o <= a1;
        @(posedge sys_clk_i);
        half_rd_o <= 1'b0;
        half_a1_o <= ~a1;
        @(posedge sys_clk_i);
        d = half_data_i;
        hi = half_is_high_i;
    endtask
    // Low half first, so the second read gets the captured high half
    task automatic rd32(input logic swap, output logic [31:0] v, output logic [1:0] hi);
        rd16(swap, v[15:0], hi[0]);
        rd16(~swap, v[31:16], hi[1]);
    endtask
endmodule

// [testbench/gp_timer_freerun_wordswap_tb.sv]
`timescale 1ns/1ps
module gp_timer_freerun_wordswap_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] haddr = 8'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic half_rd;
    logic half_a1;
    logic [15:0] half_data;
    logic half_hi;
    logic tx_load = 1'b0;
    logic [31:0] tx_word = 32'h0;
    logic tx_vld;
    logic [15:0] tx_half;
    logic rx_vld = 1'b0;
    logic [15:0] rx_half = 16'h0;
    logic [31:0] rx_word;
    logic tevt;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    gp_timer_freerun_wordswap u_dut (.sys_clk_i(clk), .rstn_i(rstn), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(), .half_rd_i(half_rd), .half_a1_i(half_a1), .half_data_o(half_data),
        .half_is_high_o(half_hi), .tx_load_i(tx_load), .tx_word_i(tx_word), .tx_ready_o(),
        .tx_half_valid_o(tx_vld), .tx_half_o(tx_half), .rx_half_valid_i(rx_vld),
        .rx_half_i(rx_half), .rx_word_valid_o(), .rx_word_o(rx_word), .timer_event_o(tevt));
    gp_host16_model u_host (.sys_clk_i(clk), .half_rd_o(half_rd), .half_a1_o(half_a1),
        .half_data_i(half_data), .half_is_high_i(half_hi));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            results();
        end
    end
    // Ready seen at negedge equals its value at the next rising edge
    task automatic wait_rdy();
        do @(negedge clk); while (hready !== 1'b1);
        @(posedge clk);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        ahb(1'b1, a, d, v);
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        ahb(1'b0, a, 32'h0, v);
        chk(what, v, exp);
    endtask
    task automatic t_regs();
        rchk("free after reset", 8'h9C, 32'h0);
        rchk("config reset", 8'h8C, 32'h0000FFFF);
        rchk("count reset", 8'h90, 32'h0000FFFF);
        rchk("order reset", 8'h98, 32'h0);
        wr(8'h98, 32'h1234ABCD);
        rchk("order rw", 8'h98, 32'h1234ABCD);
        wr(8'h90, 32'h5);
        rchk("count ro", 8'h90, 32'h0000FFFF);
        wr(8'h40, 32'h5);
        rchk("unmapped", 8'h40, 32'h0);
        wr(8'h8C, 32'h1FFF1234);
        rchk("config bits", 8'h8C, 32'h00001234);
        $display("t_regs end");
    endtask
    task automatic t_timer();
        int c;
        logic [31:0] v;
        wr(8'h8C, 32'h20000003);
        rchk("config run", 8'h8C, 32'h20000003);
        do @(negedge clk); while (tevt !== 1'b1);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (tevt !== 1'b1);
        chk("timer period", 32'(c), 32'd40);
        // Live count must sit inside the programmed range, not at reset value
        ahb(1'b0, 8'h90, 32'h0, v);
        chk("count live", 32'(v < 32'd4), 32'h1);
        @(posedge clk);
        wr(8'h8C, 32'h00000005);
        rchk("preload preset", 8'h8C, 32'h0000FFFF);
        c = 0;
        repeat (100) begin
            @(negedge clk);
            c += int'(tevt === 1'b1);
        end
        chk("halted events", 32'(c), 32'd0);
        @(posedge clk);
        $display("t_timer end");
    endtask
    task automatic t_free();
        logic [31:0] a;
        logic [31:0] b;
        ahb(1'b0, 8'h9C, 32'h0, a);
        repeat (997) @(posedge clk);
        ahb(1'b0, 8'h9C, 32'h0, b);
        chk("free rate", b - a, 32'd100);
        $display("t_free end");
    endtask
    task automatic t_half();
        logic [31:0] v;
        logic [31:0] f;
        logic [1:0] hi;
        logic [15:0] lo0;
        logic [15:0] lo1;
        logic h0;
        wr(8'h98, 32'h0);
        u_host.rd32(1'b0, v, hi);
        chk("plain route", 32'(hi), 32'h2);
        ahb(1'b0, 8'h9C, 32'h0, f);
        chk("snapshot", 32'(f - v < 32'd3), 32'h1);
        // Second read must return the captured value, not the moved-on count
        u_host.rd16(1'b0, lo0, h0);
        repeat (30) @(posedge clk);
        u_host.rd16(1'b0, lo1, h0);
        chk("snapshot held", 32'(lo1), 32'(lo0));
        wr(8'h98, 32'hFFFFFFFF);
        u_host.rd32(1'b1, v, hi);
        chk("swapped route", 32'(hi), 32'h2);
        ahb(1'b0, 8'h9C, 32'h0, f);
        chk("swapped data", 32'(f - v < 32'd3), 32'h1);
        wr(8'h98, 32'hFFFFFFFE);
        u_host.rd32(1'b0, v, hi);
        chk("near key route", 32'(hi), 32'h2);
        $display("t_half end");
    endtask
    task automatic t_net();
        tx_word <= 32'hA1B2C3D4;
        tx_load <= 1'b1;
        @(posedge clk);
        tx_load <= 1'b0;
        @(negedge clk);
        chk("tx first", 32'({tx_vld, tx_half}), 32'h1C3D4);
        @(negedge clk);
        chk("tx second", 32'({tx_vld, tx_half}), 32'h1A1B2);
        @(posedge clk);
        rx_vld <= 1'b1;
        rx_half <= 16'h1111;
        @(posedge clk);
        rx_half <= 16'h2222;
        @(posedge clk);
        rx_vld <= 1'b0;
        repeat (3) @(negedge clk);
        chk("rx word", rx_word, 32'h22221111);
        $display("t_net end");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_timer();
        t_free();
        t_half();
        t_net();
        results();
    end
endmodule
bind gp_timer_freerun_wordswap gp_timer_props u_props (.sys_clk_i, .rstn_i, .hsel_i,
    .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .hresp_o, .tx_load_i, .tx_word_i,
    .tx_ready_o, .tx_half_valid_o, .tx_half_o, .rx_half_valid_i, .rx_word_valid_o,
    .timer_event_o);
